/* File: logic/board_ident_status_regs.sv */
// read-only board identification status bank with an apb slave
//
// Summary of operation
// - board identifier parameter appears in bits 18:4 of board status word
// - design code identifier parameter appears in bits 19:0 of design code word
// - full 32-bit revision number from input port or parameter
// - device size code in bits 27:16 of front panel word
// - with front panel option on, 4-bit io identifier shows in bits 3:0
// - with front panel option off, those four bits read zero
// - board at 0x0C, design code at 0x10, revision number at 0x14
// - revision date at 0x18, front panel identification at 0x1C
`timescale 1ns/10ps
`include "ident_regs.svh"

module board_ident_status_regs #(
  parameter logic [14:0] BOARD_IDENT = 15'h0000,
  parameter logic [19:0] DESIGN_CODE_IDENT = 20'h00000,
  parameter logic [31:0] REVISION_NUMBER = 32'h0000_0000,
  parameter logic [7:0] REVISION_MONTH = 8'h01,
  parameter logic [7:0] REVISION_DAY = 8'h01,
  parameter logic [7:0] REVISION_YEAR = 8'h00,
  parameter logic [11:0] DEVICE_SIZE = 12'h000,
  parameter bit REVISION_NUMBER_FROM_PORT = 1'b0,
  parameter bit REVISION_DATE_FROM_PORT = 1'b0,
  parameter bit DEVICE_SIZE_FROM_PORT = 1'b0,
  parameter bit HAS_FRONT_PANEL_IO = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // identification inputs, held static by the system
  input wire logic [31:0] revision_number_in,
  input wire logic [23:0] revision_date_in,
  input wire logic [11:0] device_size_in,
  // front panel io identifier pins
  input wire logic [3:0] front_panel_io_in
);

  ident_pkg::bank_state_t st_r;
  ident_pkg::bank_state_t st_nxt;
  ident_pkg::ident_inputs_t values;
  logic [31:0] word;
  logic hit;
  logic [7:0] build_date_hi;

  ////////////////////////////////////////////////////////////////////////////
  // source selection

  // build-time date as mm dd yy hex digits
  always_comb begin
    build_date_hi = REVISION_MONTH;
    values.revision_number = REVISION_NUMBER_FROM_PORT ? revision_number_in
                                                       : REVISION_NUMBER;
    values.revision_date = REVISION_DATE_FROM_PORT ? revision_date_in
      : {build_date_hi, REVISION_DAY, REVISION_YEAR};
    values.device_size = DEVICE_SIZE_FROM_PORT ? device_size_in : DEVICE_SIZE;
    // the pins are asynchronous, so only the second stage is read
    values.front_panel_io = HAS_FRONT_PANEL_IO ? st_r.fpio_sync
                                               : `FRONT_PANEL_IO_RESET;
  end

  ident_word_mux #(
    .BOARD_IDENT(BOARD_IDENT),
    .DESIGN_CODE_IDENT(DESIGN_CODE_IDENT)
  ) u_mux (
    .offset(paddr),
    .values(values),
    .word(word),
    .hit(hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb access: one wait state, answer registered

  always_comb begin
    st_nxt = st_r;
    st_nxt.fpio_meta = front_panel_io_in;
    st_nxt.fpio_sync = st_r.fpio_meta;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (psel && penable && !st_r.pready) begin
      st_nxt.pready = 1'b1;
      // writes change nothing; an unmapped address answers with an error
      st_nxt.pslverr = !hit;
      st_nxt.prdata = (!pwrite && hit) ? word : `READ_DATA_RESET;
    end else if (st_r.pready) begin
      st_nxt.prdata = `READ_DATA_RESET;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;

endmodule

/* File: logic/ident_pkg.sv */
// types shared by the identification status bank
package ident_pkg;

  typedef struct packed {
    logic [31:0] revision_number;
    logic [23:0] revision_date;
    logic [11:0] device_size;
    logic [3:0] front_panel_io;
  } ident_inputs_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_answer_t;

  typedef struct packed {
    logic [3:0] fpio_meta;
    logic [3:0] fpio_sync;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bank_state_t;

endpackage

/* File: logic/ident_regs.svh */
// register offsets, field positions and reset values of the identification status bank
`ifndef IDENT_REGS_SVH
`define IDENT_REGS_SVH

`define BOARD_IDENT_STATUS_OFS 8'h0C
`define DESIGN_CODE_STATUS_OFS 8'h10
`define REVISION_NUMBER_STATUS_OFS 8'h14
`define REVISION_DATE_STATUS_OFS 8'h18
`define FRONT_PANEL_IDENT_STATUS_OFS 8'h1C

`define BOARD_IDENT_LSB 4
`define BOARD_IDENT_MSB 18
`define DESIGN_CODE_IDENT_LSB 0
`define DESIGN_CODE_IDENT_MSB 19
`define REVISION_DATE_LSB 0
`define REVISION_DATE_MSB 23
`define DEVICE_SIZE_LSB 16
`define DEVICE_SIZE_MSB 27
`define FRONT_PANEL_IO_LSB 0
`define FRONT_PANEL_IO_MSB 3

`define READ_DATA_RESET 32'h0000_0000
`define FRONT_PANEL_IO_RESET 4'h0

`endif

/* File: logic/ident_word_mux.sv */
// combinational selection of the read word for one register offset
`timescale 1ns/10ps
`include "ident_regs.svh"

module ident_word_mux #(
  parameter logic [14:0] BOARD_IDENT = 15'h0000,
  parameter logic [19:0] DESIGN_CODE_IDENT = 20'h00000
) (
  // lookup
  input wire logic [7:0] offset,
  input wire ident_pkg::ident_inputs_t values,
  // result
  output logic [31:0] word,
  output logic hit
);

  always_comb begin
    word = `READ_DATA_RESET;
    hit = 1'b1;
    case (offset)
      `BOARD_IDENT_STATUS_OFS: begin
        word[`BOARD_IDENT_MSB:`BOARD_IDENT_LSB] = BOARD_IDENT;
      end
      `DESIGN_CODE_STATUS_OFS: begin
        word[`DESIGN_CODE_IDENT_MSB:`DESIGN_CODE_IDENT_LSB] = DESIGN_CODE_IDENT;
      end
      `REVISION_NUMBER_STATUS_OFS: begin
        word = values.revision_number;
      end
      `REVISION_DATE_STATUS_OFS: begin
        word[`REVISION_DATE_MSB:`REVISION_DATE_LSB] = values.revision_date;
      end
      `FRONT_PANEL_IDENT_STATUS_OFS: begin
        word[`DEVICE_SIZE_MSB:`DEVICE_SIZE_LSB] = values.device_size;
        word[`FRONT_PANEL_IO_MSB:`FRONT_PANEL_IO_LSB] = values.front_panel_io;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

endmodule

/* File: verif/ident_chk_assertions.sv */
// apb timing and field assertions for the identification status bank
`timescale 1ns/10ps
module ident_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_rd(a);
    pready && !pwrite && paddr == a;
  endsequence
  a_one_wait: assert property (s_acc |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_ready_cause: assert property (!(psel && penable) |=> !pready) else $error("stray ready");
  a_err_decode: assert property (pready |->
    pslverr == !(paddr inside {8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C})) else $error("decode");
  a_board_rsvd: assert property (s_rd(8'h0C) |-> prdata[31:19] == '0 && prdata[3:0] == '0)
    else $error("board rsvd");
  a_code_rsvd: assert property (s_rd(8'h10) |-> prdata[31:20] == '0) else $error("code rsvd");
  a_date_rsvd: assert property (s_rd(8'h18) |-> prdata[31:24] == '0) else $error("date rsvd");
  a_panel_rsvd: assert property (s_rd(8'h1C) |-> prdata[31:28] == '0 && prdata[15:4] == '0)
    else $error("panel rsvd");
  a_idle_zero: assert property (!pready |-> prdata == '0) else $error("idle data");
endmodule
bind board_ident_status_regs ident_chk chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr);

/* File: verif/tb.sv */
// self-checking bench for the identification status bank
`timescale 1ns/10ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] fpio;
  logic [32:0] got, got_off;
  logic [31:0] prdata_off, rev_in;
  logic [23:0] date_in;
  logic [11:0] size_in;
  logic pready_off, pslverr_off;
  int n_fail = 0;
  int samples_checked = 0;
  typedef struct {logic [7:0] a; logic [32:0] e;} row_t;
  row_t rows[7] = '{'{8'h0C, 33'h0_0002_A5B0}, '{8'h10, 33'h0_0003_C4D5},
    '{8'h14, 33'h0_1234_5678}, '{8'h18, 33'h0_0001_0100}, '{8'h1C, 33'h0_0ABC_0006},
    '{8'h00, 33'h1_0000_0000}, '{8'h20, 33'h1_0000_0000}};
  // date port differs from the default date parameters, so a wrong source choice shows
  board_ident_status_regs #(.BOARD_IDENT(15'h2A5B), .DESIGN_CODE_IDENT(20'h3C4D5),
    .REVISION_NUMBER_FROM_PORT(1'h1), .DEVICE_SIZE_FROM_PORT(1'h1),
    .HAS_FRONT_PANEL_IO(1'h1)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .revision_number_in(rev_in),
    .revision_date_in(date_in), .device_size_in(size_in), .front_panel_io_in(fpio));
  // all options off: parameters win over the ports, panel bits read zero
  board_ident_status_regs dut_off (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata(prdata_off), .pready(pready_off), .pslverr(pslverr_off),
    .revision_number_in(rev_in), .revision_date_in(date_in), .device_size_in(size_in),
    .front_panel_io_in(fpio));
  ////////////////////////////////////////////////////////////////
  task chk(input logic [32:0] s, input logic [32:0] e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task give_verdict;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // leading edge keeps a release and the next setup out of one time step
  task xfer(input logic w, input logic [7:0] a, output logic [32:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'hFFFF_FFFF;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
    r = {pslverr, prdata};
    got_off = {pslverr_off, prdata_off};
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #20000;
    n_fail++;
    give_verdict;
  end
  initial begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 8'h00; pwdata = 32'h0; fpio = 4'h6;
    rev_in = 32'h1234_5678; date_in = 24'hFFFFFF; size_in = 12'hABC;
    repeat (20) @(posedge pclk);
    chk({pready, prdata}, 33'h0);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    foreach (rows[i]) begin
      xfer(1'h0, rows[i].a, got);
      chk(got, rows[i].e);
    end
    xfer(1'h1, 8'h14, got);
    chk(got, 33'h0);
    xfer(1'h0, 8'h14, got);
    chk(got, 33'h0_1234_5678);
    chk(got_off, 33'h0);
    rev_in <= 32'h8765_4321;
    fpio <= 4'h9;
    repeat (3) @(posedge pclk);
    xfer(1'h0, 8'h14, got);
    chk(got, 33'h0_8765_4321);
    xfer(1'h0, 8'h1C, got);
    chk(got, 33'h0_0ABC_0009);
    chk(got_off, 33'h0);
    xfer(1'h0, 8'h18, got);
    chk(got_off, 33'h0_0001_0100);
    @(posedge pclk);
    presetn <= 1'h0;
    @(posedge pclk);
    chk({pready, prdata}, 33'h0);
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    xfer(1'h0, 8'h0C, got);
    chk(got, 33'h0_0002_A5B0);
    give_verdict;
  end
endmodule
